// file: rtl/power_source_and_sequence_control.sv
// power source selection, rail sequencing, supervisory reset and flags, with an ahb-lite slave
//
// What this block does
// [R1] low-battery flag pulled low while battery sense is below its reference.
// [R2] wall adapter present: draw from external rail, open the port switch.
// [R3] external-power-good low on wall adapter, or port above threshold without suspend.
// [R4] no draw from external rail until its undervoltage detector reports it good.
// [R5] port switch closes only with port good, no suspend, no wall adapter.
// [R6] port current limit high when select input high, low otherwise; defaults low.
// [R7] suspend high disables all port power functions, switch open, standby draw only.
// [R8] main rail connects fixed delay after core regulates, never before core.
// [R9] card power output connects fixed delay after core regulates.
// [R10] device turns on when the active-low power key is pulled low.
// [R11] outside party holds key low until host drives power-hold high.
// [R12] key status output follows the power key, low while key low.
// [R13] power-hold input high turns the device on; defaults low.
// [R14] mode high allows pulse skipping at light load; low forces fixed-frequency pwm.
// [R15] powered from port or wall adapter forces fixed-frequency pwm regardless of mode.
// [R16] initial power-up forces pwm for the whole reset delay timeout.
// [R17] reset held low at power-up; timer starts once core and main regulate.
// [R18] reset pulled low when main or core rail leaves regulation.
// [R19] reset pulled low while powering off.
// [R20] source priority: wall adapter, then bus port, then battery.
// [R21] power-up order: internal rail, core rail, main rail, card output.
// [R22] enabled while key low or hold high and the soft-off bit is clear; power-off when both inactive.
// [R23] delays are clocked counters, restarting from zero when regulation is lost.
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_regs.svh"

module power_source_and_sequence_control #(
  parameter int MAIN_DELAY_CYC  = `MAIN_DELAY_NS / `CLK_PERIOD_NS,
  parameter int CARD_DELAY_CYC  = `CARD_DELAY_NS / `CLK_PERIOD_NS,
  parameter int RESET_DELAY_CYC = `RESET_DELAY_NS / `CLK_PERIOD_NS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        battery_sense_in,
  input  wire logic        wall_adapter_sense,
  input  wire logic        port_voltage_good,
  input  wire logic        port_suspend,
  input  wire logic        port_high_power_select,
  input  wire logic        external_rail_good,
  input  wire logic        power_key_n,
  input  wire logic        host_power_hold,
  input  wire logic        mode_select,
  input  wire logic        int_rail_good,
  input  wire logic        core_feedback,
  input  wire logic        main_rail_good,
  output logic             low_battery_flag_n_o,
  output logic             low_battery_flag_n_oe,
  output logic             external_power_good_n_o,
  output logic             external_power_good_n_oe,
  output logic             key_status_n_o,
  output logic             key_status_n_oe,
  output logic             reset_n_o,
  output logic             reset_n_oe,
  output logic             draw_external_supply_rail,
  output logic             port_switch_on,
  output logic             port_current_high,
  output logic             port_standby,
  output logic             int_rail_enable,
  output logic             core_rail_enable,
  output logic             main_rail_connect,
  output logic             card_power_output,
  output logic             force_pwm
);

  // ==========================================================================
  // address decode
  // ==========================================================================
  function automatic logic [1:0] reg_hit(input logic [31:0] addr);
    logic [1:0] hit;
    hit = 2'b00;
    if (addr[31:`ADDR_DEC_W] == '0) begin
      if (addr[`ADDR_DEC_W-1:0] == `CTRL_OFFSET) begin
        hit = 2'b01;
      end else if (addr[`ADDR_DEC_W-1:0] == `STATUS_OFFSET) begin
        hit = 2'b10;
      end
    end
    return hit;
  endfunction

  // ==========================================================================
  // declarations
  // ==========================================================================
  localparam power_seq_pkg::delay_cnt_t LIM_MAIN  = `DELAY_CNT_W'(MAIN_DELAY_CYC);
  localparam power_seq_pkg::delay_cnt_t LIM_CARD  = `DELAY_CNT_W'(CARD_DELAY_CYC);
  localparam power_seq_pkg::delay_cnt_t LIM_RESET = `DELAY_CNT_W'(RESET_DELAY_CYC);

  power_seq_pkg::seq_state_e    state_r;
  power_seq_pkg::seq_state_e    state_nxt;
  power_seq_pkg::power_source_e source;
  power_seq_pkg::delay_cnt_t    dly_cnt_r [3];
  logic [2:0]                   dly_en;
  logic [2:0]                   dly_done;
  logic [31:0]                  ctrl_r;
  logic [31:0]                  status;
  logic                         wr_pend_r;
  logic                         init_done_r;
  logic                         enabled;
  logic                         wall_ok;
  logic                         port_ok;
  logic                         seq_on;
  logic                         release_ok;
  logic                         ext_source;
  logic [1:0]                   hit;

  // ==========================================================================
  // source selection
  // ==========================================================================
  assign wall_ok = wall_adapter_sense; // [R2] [R20]
  // suspend and wall adapter both keep the port path out of the picture
  assign port_ok = port_voltage_good & ~port_suspend & ~wall_adapter_sense; // [R5] [R7] [R20]
  assign ext_source = (wall_ok | port_ok) & external_rail_good; // [R4]

  always_comb begin
    if (wall_ok & external_rail_good) begin
      source = power_seq_pkg::SRC_WALL; // [R20]
    end else if (port_ok & external_rail_good) begin
      source = power_seq_pkg::SRC_PORT; // [R20]
    end else begin
      source = power_seq_pkg::SRC_BATTERY; // [R20]
    end
  end

  // ==========================================================================
  // sequencing state machine
  // ==========================================================================
  assign enabled = (~power_key_n | host_power_hold) & ~ctrl_r[`CTRL_SOFT_OFF_BIT]; // [R10] [R13] [R22]
  assign seq_on = (state_r == power_seq_pkg::ST_ON);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      power_seq_pkg::ST_OFF: begin
        if (enabled) begin
          state_nxt = power_seq_pkg::ST_INT_UP; // [R10] [R13] [R21]
        end
      end
      power_seq_pkg::ST_INT_UP: begin
        if (!enabled) begin
          state_nxt = power_seq_pkg::ST_DOWN; // [R22]
        end else if (int_rail_good) begin
          state_nxt = power_seq_pkg::ST_ON; // [R21]
        end
      end
      power_seq_pkg::ST_ON: begin
        if (!enabled) begin
          state_nxt = power_seq_pkg::ST_DOWN; // [R22]
        end
      end
      power_seq_pkg::ST_DOWN: begin
        state_nxt = power_seq_pkg::ST_OFF;
      end
      default: begin
        state_nxt = power_seq_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= power_seq_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // delay counters: main connect, card connect, reset release
  // ==========================================================================
  assign dly_en[0] = seq_on & core_feedback; // [R8] [R23]
  assign dly_en[1] = seq_on & core_feedback; // [R9] [R23]
  // reset timer waits for the main rail really connected and in regulation
  assign dly_en[2] = seq_on & core_feedback & main_rail_good & dly_done[0]; // [R17] [R23]

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_dly
      power_seq_pkg::delay_cnt_t lim;
      assign lim = (gi == 0) ? LIM_MAIN : ((gi == 1) ? LIM_CARD : LIM_RESET);
      assign dly_done[gi] = dly_en[gi] & (dly_cnt_r[gi] == lim);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dly_cnt_r[gi] <= '0;
        end else if (!dly_en[gi]) begin
          dly_cnt_r[gi] <= '0; // [R23]
        end else if (dly_cnt_r[gi] != lim) begin
          dly_cnt_r[gi] <= dly_cnt_r[gi] + `DELAY_CNT_W'(1); // [R23]
        end
      end
    end
  endgenerate

  // once set, stays until power-off so later rail dips do not re-force pwm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_done_r <= 1'b0;
    end else if (!seq_on) begin
      init_done_r <= 1'b0; // [R16]
    end else if (dly_done[2]) begin
      init_done_r <= 1'b1; // [R16]
    end
  end

  assign release_ok = dly_done[2] & enabled; // [R17] [R18] [R19]

  // ==========================================================================
  // pin and rail outputs
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_battery_flag_n_o     <= 1'b0;
      low_battery_flag_n_oe    <= 1'b0;
      external_power_good_n_o  <= 1'b0;
      external_power_good_n_oe <= 1'b0;
      key_status_n_o           <= 1'b0;
      key_status_n_oe          <= 1'b0;
    end else begin
      low_battery_flag_n_oe    <= ~battery_sense_in; // [R1]
      external_power_good_n_oe <= wall_ok | (port_voltage_good & ~port_suspend); // [R3]
      key_status_n_oe          <= ~power_key_n; // [R12]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_n_o  <= 1'b0;
      reset_n_oe <= 1'b1;
    end else begin
      reset_n_oe <= ~release_ok; // [R17] [R18] [R19]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      draw_external_supply_rail <= 1'b0;
      port_switch_on            <= 1'b0;
      port_current_high         <= 1'b0;
      port_standby              <= 1'b0;
    end else begin
      draw_external_supply_rail <= ext_source; // [R2] [R4]
      port_switch_on            <= port_ok; // [R5] [R7] [R2]
      port_current_high         <= port_high_power_select & ~port_suspend; // [R6] [R7]
      port_standby              <= port_suspend; // [R7]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_rail_enable   <= 1'b0;
      core_rail_enable  <= 1'b0;
      main_rail_connect <= 1'b0;
      card_power_output <= 1'b0;
    end else begin
      int_rail_enable   <= (state_nxt == power_seq_pkg::ST_INT_UP) |
                           (state_nxt == power_seq_pkg::ST_ON); // [R21]
      core_rail_enable  <= (state_nxt == power_seq_pkg::ST_ON); // [R21]
      main_rail_connect <= dly_done[0]; // [R8] [R21]
      card_power_output <= dly_done[1] & dly_done[0]; // [R9] [R21]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_pwm <= 1'b1;
    end else begin
      force_pwm <= ~mode_select | // [R14]
                   (source != power_seq_pkg::SRC_BATTERY) | // [R15]
                   ~init_done_r | // [R16]
                   ctrl_r[`CTRL_FORCE_PWM_BIT];
    end
  end

  // ==========================================================================
  // ahb-lite slave: zero wait states, always okay
  // ==========================================================================
  assign hit = reg_hit(haddr);

  always_comb begin
    status = '0;
    status[`STAT_STATE_LSB +: 4]    = state_r;
    status[`STAT_SOURCE_LSB +: 2]   = source;
    status[`STAT_INT_EN_BIT]        = int_rail_enable;
    status[`STAT_CORE_EN_BIT]       = core_rail_enable;
    status[`STAT_MAIN_ON_BIT]       = main_rail_connect;
    status[`STAT_CARD_ON_BIT]       = card_power_output;
    status[`STAT_RESET_REL_BIT]     = ~reset_n_oe;
    status[`STAT_FORCE_PWM_BIT]     = force_pwm;
    status[`STAT_PORT_SW_BIT]       = port_switch_on;
    status[`STAT_PORT_HI_BIT]       = port_current_high;
    status[`STAT_EXT_GOOD_BIT]      = external_power_good_n_oe;
    status[`STAT_LOW_BAT_BIT]       = low_battery_flag_n_oe;
    status[`STAT_INIT_DONE_BIT]     = init_done_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data is fetched in the address phase so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= '0;
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= hsel & hready & htrans[1] & hwrite & hit[0];
      if (hsel & hready & htrans[1] & ~hwrite) begin
        hrdata <= hit[0] ? ctrl_r : (hit[1] ? status : '0);
      end else begin
        hrdata <= '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CTRL_RESET_VALUE;
    end else if (wr_pend_r) begin
      ctrl_r <= {30'h0, hwdata[`CTRL_FORCE_PWM_BIT], hwdata[`CTRL_SOFT_OFF_BIT]};
    end
  end

endmodule

`default_nettype wire

// file: include/power_seq_regs.svh
// register offsets, field positions, reset values and timing figures of the sequencer
`ifndef POWER_SEQ_REGS_SVH
`define POWER_SEQ_REGS_SVH

`define CLK_PERIOD_NS        5
`define MAIN_DELAY_NS        800000
`define CARD_DELAY_NS        500000
`define RESET_DELAY_NS       262000000

`define DELAY_CNT_W          26

`define CTRL_OFFSET          8'h00
`define STATUS_OFFSET        8'h04
`define ADDR_DEC_W           8

`define CTRL_SOFT_OFF_BIT    0
`define CTRL_FORCE_PWM_BIT   1
`define CTRL_RESET_VALUE     32'h0000_0000

`define STAT_STATE_LSB       0
`define STAT_SOURCE_LSB      4
`define STAT_INT_EN_BIT      6
`define STAT_CORE_EN_BIT     7
`define STAT_MAIN_ON_BIT     8
`define STAT_CARD_ON_BIT     9
`define STAT_RESET_REL_BIT   10
`define STAT_FORCE_PWM_BIT   11
`define STAT_PORT_SW_BIT     12
`define STAT_PORT_HI_BIT     13
`define STAT_EXT_GOOD_BIT    14
`define STAT_LOW_BAT_BIT     15
`define STAT_INIT_DONE_BIT   16

`endif

// file: include/power_seq_pkg.sv
// types shared by the power source and sequence controller
package power_seq_pkg;

  typedef enum logic [3:0] {
    ST_OFF    = 4'b0001,
    ST_INT_UP = 4'b0010,
    ST_ON     = 4'b0100,
    ST_DOWN   = 4'b1000
  } seq_state_e;

  typedef enum logic [1:0] {
    SRC_BATTERY = 2'h0,
    SRC_PORT    = 2'h1,
    SRC_WALL    = 2'h2
  } power_source_e;

  typedef logic [25:0] delay_cnt_t;

endpackage

// file: tb/power_seq_assertions.sv
// port-level checker of the power source and sequence controller
`timescale 1ns/1ps
`default_nettype none
module power_seq_checker #(
  parameter int MAIN_DELAY_CYC  = 20,
  parameter int CARD_DELAY_CYC  = 12,
  parameter int RESET_DELAY_CYC = 40
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic battery_sense_in,
  input wire logic wall_adapter_sense,
  input wire logic port_voltage_good,
  input wire logic port_suspend,
  input wire logic external_rail_good,
  input wire logic power_key_n,
  input wire logic mode_select,
  input wire logic core_feedback,
  input wire logic main_rail_good,
  input wire logic low_battery_flag_n_oe,
  input wire logic external_power_good_n_oe,
  input wire logic key_status_n_oe,
  input wire logic reset_n_oe,
  input wire logic port_switch_on,
  input wire logic main_rail_connect,
  input wire logic card_power_output,
  input wire logic force_pwm
);
  int core_cnt;
  int rail_cnt;
  // ========
  // run lengths, saturating so long runs never wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_cnt <= 0;
      rail_cnt <= 0;
    end else begin
      core_cnt <= core_feedback ? core_cnt + (core_cnt < 999) : 0;
      rail_cnt <= (core_feedback && main_rail_good) ? rail_cnt + (rail_cnt < 999) : 0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ========
  // pins and flags
  property p_low_bat;
    hresetn |=> low_battery_flag_n_oe == !$past(battery_sense_in);
  endproperty
  a_low_bat: assert property (p_low_bat) else $error("low battery flag wrong");
  property p_ext_good;
    hresetn |=> external_power_good_n_oe == ($past(wall_adapter_sense)
      || ($past(port_voltage_good) && !$past(port_suspend)));
  endproperty
  a_ext_good: assert property (p_ext_good) else $error("power good wrong");
  property p_port_sw;
    hresetn |=> port_switch_on == ($past(port_voltage_good) && !$past(port_suspend)
      && !$past(wall_adapter_sense));
  endproperty
  a_port_sw: assert property (p_port_sw) else $error("port switch wrong");
  property p_key_stat;
    hresetn |=> key_status_n_oe == !$past(power_key_n);
  endproperty
  a_key_stat: assert property (p_key_stat) else $error("key status wrong");
  // ========
  // sequencing and reset
  sequence s_main_on;
    $rose(main_rail_connect);
  endsequence
  sequence s_core_lost;
    $fell(core_feedback);
  endsequence
  property p_main_dly;
    s_main_on |-> core_cnt > MAIN_DELAY_CYC;
  endproperty
  a_main_dly: assert property (p_main_dly) else $error("main rail early");
  property p_card_dly;
    $rose(card_power_output) |-> main_rail_connect && core_cnt > CARD_DELAY_CYC;
  endproperty
  a_card_dly: assert property (p_card_dly) else $error("card output early");
  property p_core_loss;
    s_core_lost |=> reset_n_oe && !main_rail_connect && !card_power_output;
  endproperty
  a_core_loss: assert property (p_core_loss) else $error("core loss ignored");
  property p_rst_dly;
    $fell(reset_n_oe) |-> rail_cnt > RESET_DELAY_CYC;
  endproperty
  a_rst_dly: assert property (p_rst_dly) else $error("reset released early");
  property p_pwm;
    (!mode_select || (wall_adapter_sense && external_rail_good)) |=> force_pwm;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm not forced");
endmodule
`default_nettype wire

// file: tb/rail_host_model.sv
// far side: rail supervisors answering the enables, and the host hold pin
`timescale 1ns/1ps
`default_nettype none
module rail_host_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [2:0] lag,
  input  wire logic       core_fault,
  input  wire logic       hold_allowed,
  input  wire logic       int_rail_enable,
  input  wire logic       core_rail_enable,
  input  wire logic       main_rail_connect,
  input  wire logic       reset_n_oe,
  output logic            int_rail_good,
  output logic            core_feedback,
  output logic            main_rail_good,
  output logic            host_power_hold
);
  logic [7:0] int_sh;
  logic [7:0] core_sh;
  logic [7:0] main_sh;
  // ========
  // rails settle lag+1 cycles after enable; lag 0 answers one cycle after enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_sh  <= 8'h00;
      core_sh <= 8'h00;
      main_sh <= 8'h00;
    end else begin
      int_sh  <= {int_sh[6:0], int_rail_enable};
      core_sh <= {core_sh[6:0], core_rail_enable};
      main_sh <= {main_sh[6:0], main_rail_connect};
    end
  end
  assign int_rail_good  = int_sh[lag] & int_rail_enable;
  assign core_feedback  = core_sh[lag] & core_rail_enable & ~core_fault;
  assign main_rail_good = main_sh[lag] & main_rail_connect;
  // host latches hold once out of reset; weak pull-down otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_power_hold <= 1'b0;
    end else begin
      host_power_hold <= hold_allowed & (host_power_hold | ~reset_n_oe);
    end
  end
endmodule
`default_nettype wire

// file: tb/power_source_and_sequence_control_tb_top.sv
// testbench top of the power source and sequence controller
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_regs.svh"
module power_source_and_sequence_control_tb_top;
  localparam int MAIN_DELAY_CYC  = 20;
  localparam int CARD_DELAY_CYC  = 12;
  localparam int RESET_DELAY_CYC = 40;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_fault, hold_allowed;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, lag;
  logic battery_sense_in, wall_adapter_sense, port_voltage_good, port_suspend;
  logic port_high_power_select, external_rail_good, power_key_n, host_power_hold;
  logic mode_select, int_rail_good, core_feedback, main_rail_good;
  logic low_battery_flag_n_o, low_battery_flag_n_oe, external_power_good_n_o;
  logic external_power_good_n_oe, key_status_n_o, key_status_n_oe, reset_n_o, reset_n_oe;
  logic draw_external_supply_rail, port_switch_on, port_current_high, port_standby;
  logic int_rail_enable, core_rail_enable, main_rail_connect, card_power_output, force_pwm;
  int fails;
  int samples_checked;
  assign hready = hreadyout;
  power_source_and_sequence_control #(.MAIN_DELAY_CYC(MAIN_DELAY_CYC),
    .CARD_DELAY_CYC(CARD_DELAY_CYC), .RESET_DELAY_CYC(RESET_DELAY_CYC))
    power_source_and_sequence_control_i (.*);
  rail_host_model rail_host_model_i (.*);
  // ========
  // shared tasks
  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic sel_sig(input int k);
    case (k)
      0: return main_rail_connect;
      1: return card_power_output;
      2: return reset_n_oe;
      3: return core_feedback;
      4: return host_power_hold;
      5: return int_rail_enable;
      default: return main_rail_good;
    endcase
  endfunction
  // bounded poll; the watchdog ends a real hang
  task automatic wait_for(input int k, input logic v, output int n);
    n = 0;
    while (sel_sig(k) !== v && n < 5000) begin
      @(posedge hclk);
      n++;
    end
  endtask
  // ========
  // scenarios
  task automatic t_flags();
    logic w, p, s, e, h, b, ok;
    for (int i = 0; i < 64; i++) begin
      {w, p, s, e, h, b} = i[5:0];
      ok = p & ~s & ~w;
      @(posedge hclk);
      {wall_adapter_sense, port_voltage_good, port_suspend} <= {w, p, s};
      {external_rail_good, port_high_power_select, battery_sense_in} <= {e, h, b};
      repeat (2) @(posedge hclk);
      #1;
      check_val({low_battery_flag_n_oe, external_power_good_n_oe, port_switch_on,
        draw_external_supply_rail, port_standby, port_current_high, key_status_n_oe},
        {~b, w | (p & ~s), ok, (w | ok) & e, s, h & ~s, 1'b0});
    end
  endtask
  task automatic t_power_up();
    int n;
    @(posedge hclk);
    {wall_adapter_sense, port_voltage_good, port_suspend} <= 3'h0;
    {external_rail_good, battery_sense_in, mode_select} <= 3'h7;
    {power_key_n, hold_allowed, lag} <= {1'b0, 1'b1, 3'h3};
    wait_for(5, 1'b1, n);
    check_val({31'h0, n < 4}, 32'h1);
    wait_for(3, 1'b1, n);
    wait_for(0, 1'b1, n);
    check_val({30'h0, n > MAIN_DELAY_CYC && n <= MAIN_DELAY_CYC + 3, force_pwm}, 32'h3);
    wait_for(1, 1'b1, n);
    check_val({25'h0, main_rail_connect, core_rail_enable, hresp, low_battery_flag_n_o,
      external_power_good_n_o, key_status_n_o, reset_n_o}, 32'h60);
    wait_for(6, 1'b1, n);
    wait_for(2, 1'b0, n);
    check_val({31'h0, n > RESET_DELAY_CYC && n <= RESET_DELAY_CYC + 3}, 32'h1);
    wait_for(4, 1'b1, n);
    power_key_n <= 1'b1;
    repeat (4) @(posedge hclk);
    #1;
    check_val({29'h0, int_rail_enable, reset_n_oe, force_pwm}, 32'h4);
  endtask
  task automatic t_core_drop();
    int n;
    @(posedge hclk);
    core_fault <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    check_val({30'h0, reset_n_oe, main_rail_connect}, 32'h2);
    @(posedge hclk);
    core_fault <= 1'b0;
    wait_for(3, 1'b1, n);
    wait_for(0, 1'b1, n);
    check_val({31'h0, n > MAIN_DELAY_CYC && n <= MAIN_DELAY_CYC + 3}, 32'h1);
    wait_for(2, 1'b0, n);
  endtask
  task automatic t_regs();
    logic [31:0] rd, st;
    ahb(1'b0, {24'h0, `STATUS_OFFSET}, 32'h0, st);
    check_val(st & 32'h0000_043F, 32'h0000_0404);
    ahb(1'b1, {24'h0, `CTRL_OFFSET}, 32'h0000_0002, rd);
    ahb(1'b0, {24'h0, `CTRL_OFFSET}, 32'h0, rd);
    check_val({rd[30:0], force_pwm}, 32'h0000_0005);
    ahb(1'b1, {24'h0, `CTRL_OFFSET}, 32'h0, rd);
    ahb(1'b1, {24'h0, `STATUS_OFFSET}, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 32'h0000_0010, 32'h0, rd);
    check_val(rd, 32'h0);
    ahb(1'b0, {24'h0, `STATUS_OFFSET}, 32'h0, rd);
    check_val(rd, st);
    for (int j = 0; j < 3; j++) begin
      @(posedge hclk);
      wall_adapter_sense <= (j == 0);
      port_voltage_good  <= (j < 2);
      repeat (3) @(posedge hclk);
      ahb(1'b0, {24'h0, `STATUS_OFFSET}, 32'h0, rd);
      check_val({rd[5:4], force_pwm}, {j == 0, j == 1, j < 2});
    end
  endtask
  task automatic t_power_off();
    logic [31:0] rd;
    ahb(1'b1, {24'h0, `CTRL_OFFSET}, 32'h0000_0001, rd);
    repeat (3) @(posedge hclk);
    #1;
    check_val({29'h0, reset_n_oe, int_rail_enable, host_power_hold}, 32'h5);
    ahb(1'b1, {24'h0, `CTRL_OFFSET}, 32'h0, rd);
    @(posedge hclk);
    hold_allowed <= 1'b0;
    repeat (6) @(posedge hclk);
    #1;
    check_val({30'h0, reset_n_oe, int_rail_enable}, 32'h2);
  endtask
  // ========
  // clock, reset, sequence and watchdog
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = {5'h0, 64'h0, 3'h2};
    {battery_sense_in, wall_adapter_sense, port_voltage_good, port_suspend} = 4'h0;
    {port_high_power_select, external_rail_good, power_key_n, mode_select} = 4'h2;
    {core_fault, hold_allowed, lag} = 5'h0;
    repeat (8) @(posedge hclk);
    check_val({29'h0, hreadyout, reset_n_oe, force_pwm}, 32'h3);
    hresetn <= 1'b1;
    t_flags();
    t_power_up();
    t_core_drop();
    t_regs();
    t_power_off();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    wrap_up();
  end
endmodule
bind power_source_and_sequence_control power_seq_checker #(.MAIN_DELAY_CYC(MAIN_DELAY_CYC),
  .CARD_DELAY_CYC(CARD_DELAY_CYC), .RESET_DELAY_CYC(RESET_DELAY_CYC)) power_seq_checker_i (.*);
`default_nettype wire
